//--- logic/ffp_pkg.sv
// shared constants and types for the four-phase fetch/execute sequencer
package ffp_pkg;

  // widths and phase count
  localparam int PC_W = 11;
  localparam int DW = 8;
  localparam int IW = 16;
  localparam int AW = 8;
  localparam int PH_COUNT = 4;

  // wake-up start-up counts in system clock periods, and the call stack depth
  localparam int SST_CRYSTAL_OSCILLATOR_CYC = 1024;
  localparam int SST_RC_CYC = 16;
  localparam int STACK_DEPTH = 8;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } ffp_phase_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_START = 2'b10
  } ffp_state_t;

  // instruction fields
  localparam int CLS_MSB = 15;
  localparam int CLS_LSB = 13;
  localparam int DEST_BIT = 11;
  localparam int OP_MSB = 10;
  localparam int OP_LSB = 8;
  localparam int SKIP_INV_BIT = 8;
  localparam int HALT_BIT = 0;

  // instruction classes
  localparam logic [2:0] CL_ALUM = 3'h0;
  localparam logic [2:0] CL_ALUI = 3'h1;
  localparam logic [2:0] CL_STORE = 3'h2;
  localparam logic [2:0] CL_SKIP = 3'h3;
  localparam logic [2:0] CL_JMP = 3'h4;
  localparam logic [2:0] CL_CALL = 3'h5;
  localparam logic [2:0] CL_RET = 3'h6;
  localparam logic [2:0] CL_SYS = 3'h7;

  // arithmetic unit operations
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;
  localparam logic [2:0] OP_MOV = 3'h5;
  localparam logic [2:0] OP_INC = 3'h6;
  localparam logic [2:0] OP_RLC = 3'h7;

  // control registers mapped at the bottom of data memory
  localparam logic [7:0] SFR_IND = 8'h00;
  localparam logic [7:0] SFR_PTR = 8'h01;
  localparam logic [7:0] SFR_ACC = 8'h02;
  localparam logic [7:0] SFR_PCL = 8'h03;
  localparam logic [7:0] SFR_COUNT = 8'h04;

  // reset values
  localparam logic [15:0] NOP_WORD = 16'hE000;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [7:0] ACC_RST = 8'h00;

endpackage

//--- logic/ffp_phase_gen.sv
// four non-overlapping phase generator
`timescale 1ns/1ps
module ffp_phase_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  // phases
  output ffp_pkg::ffp_phase_t phase_o,
  output logic [3:0] phase_clocks_o
);

  ffp_pkg::ffp_phase_t ph_q;
  ffp_pkg::ffp_phase_t ph_d;

  // advance only while running; a stopped core rests at the first phase
  assign ph_d = run_i ? ffp_pkg::ffp_phase_t'(2'(ph_q + 2'h1)) : ph_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= ffp_pkg::PH_T1;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign phase_o = ph_q;
  // one-hot, so no two phases are ever active together
  assign phase_clocks_o = run_i ? 4'(4'h1 << ph_q) : 4'h0;

  a_phase_order: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && ph_q == ffp_pkg::PH_T2 |=> ph_q == ffp_pkg::PH_T3)
    else $error("phase did not follow T2 with T3");

  a_cycle_four: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_i && ph_q == ffp_pkg::PH_T1) ##1 (run_i && ph_q != ffp_pkg::PH_T1)[*3]
    |=> ph_q == ffp_pkg::PH_T1)
    else $error("instruction cycle is not four clocks");

  a_reset_first: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> ph_q == ffp_pkg::PH_T1)
    else $error("phase not at T1 after reset");

endmodule // ffp_phase_gen

//--- logic/ffp_core.sv
// instruction sequencer: phases, fetch pipeline, arithmetic unit and wake-up
// Operation
// - four non-overlapping phases are made from the system clock and run in fixed order.
// - the program counter steps at the start of the first phase while the fetch begins.
// - phases one to four decode and execute the instruction held in the pipeline.
// - one pass through the four phases is one instruction cycle of four clocks.
// - the next fetch overlaps the current execution, giving one instruction per cycle.
// - jumps, calls and returns take two cycles: one to get the target, one to branch.
// - an eight-bit arithmetic unit serves arithmetic, logic, rotate, increment and tests.
// - operands move through the accumulator and the arithmetic unit only.
// - control registers sit in data memory and are reached directly or indirectly.
// - on wake from halt execution waits 1024 clocks with crystal, 16 with rc oscillator.
// - a taken skip discards the already fetched word and runs a dummy cycle instead.
// - a write to the pc low byte jumps inside the current page with one dummy cycle.
`timescale 1ns/1ps
module ffp_core #(
  parameter int SST_CRYSTAL_OSCILLATOR_CYC = ffp_pkg::SST_CRYSTAL_OSCILLATOR_CYC,
  parameter int SST_RC_CYC = ffp_pkg::SST_RC_CYC,
  parameter int STACK_DEPTH = ffp_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // program memory, synchronous read
  output logic [ffp_pkg::PC_W-1:0] pmem_addr_o,
  output logic pmem_rd_o,
  input wire logic [ffp_pkg::IW-1:0] pmem_data_i,
  // data memory, synchronous read
  output logic [ffp_pkg::AW-1:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic [ffp_pkg::DW-1:0] dmem_wdata_o,
  input wire logic [ffp_pkg::DW-1:0] dmem_rdata_i,
  // pins
  input wire logic wake_i,
  input wire logic osc_rc_i,
  // status
  output logic [3:0] phase_clocks_o,
  output logic halted_o,
  output logic [ffp_pkg::DW-1:0] acc_o,
  output logic [ffp_pkg::PC_W-1:0] pc_o
);

  localparam int CNT_W = $clog2(SST_CRYSTAL_OSCILLATOR_CYC) + 1;
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (SST_RC_CYC < 1 || SST_CRYSTAL_OSCILLATOR_CYC < SST_RC_CYC) begin : g_bad_sst
    $error("start-up counts must be at least one and rc not above crystal");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_stack
    $error("stack depth must be a power of two of at least two");
  end

  // pin synchronisers
  logic [1:0] wake_sync_q;
  logic [1:0] rc_sync_q;
  logic wake_s;
  logic rc_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_sync_q <= 2'h0;
      rc_sync_q <= 2'h0;
    end else begin
      wake_sync_q <= {wake_sync_q[0], wake_i};
      rc_sync_q <= {rc_sync_q[0], osc_rc_i};
    end
  end
  assign wake_s = wake_sync_q[1];
  assign rc_s = rc_sync_q[1];

  // sequencing state
  ffp_pkg::ffp_state_t st_q;
  ffp_pkg::ffp_phase_t ph;
  logic run;
  logic [CNT_W-1:0] cnt_q;

  assign run = (st_q == ffp_pkg::ST_RUN);

  ffp_phase_gen u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .phase_o(ph),
    .phase_clocks_o(phase_clocks_o)
  );

  // pipeline registers
  logic [ffp_pkg::PC_W-1:0] fa_q;
  logic [ffp_pkg::PC_W-1:0] pc_q;
  logic [ffp_pkg::IW-1:0] fetch_q;
  logic [ffp_pkg::IW-1:0] ir_q;
  logic [ffp_pkg::DW-1:0] acc_q;
  logic [ffp_pkg::DW-1:0] ptr_q;
  logic [ffp_pkg::DW-1:0] opnd_q;
  logic c_q;
  logic [ffp_pkg::PC_W-1:0] stk_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [ffp_pkg::AW-1:0] dmem_addr_q;
  logic dmem_we_q;
  logic [ffp_pkg::DW-1:0] dmem_wdata_q;

  // decode of the held instruction
  logic [2:0] cls;
  logic [2:0] op;
  logic dest_mem;
  logic [7:0] fld;
  logic [ffp_pkg::AW-1:0] eff_addr;
  logic is_sfr;
  logic [ffp_pkg::DW-1:0] sfr_val;
  logic [ffp_pkg::DW-1:0] opnd_d;

  assign cls = ir_q[ffp_pkg::CLS_MSB:ffp_pkg::CLS_LSB];
  assign op = ir_q[ffp_pkg::OP_MSB:ffp_pkg::OP_LSB];
  assign dest_mem = ir_q[ffp_pkg::DEST_BIT];
  assign fld = ir_q[7:0];
  // the indirect slot redirects through the pointer register
  assign eff_addr = (fld == ffp_pkg::SFR_IND) ? ptr_q : fld;
  assign is_sfr = (eff_addr < ffp_pkg::SFR_COUNT);
  assign sfr_val = (eff_addr == ffp_pkg::SFR_PTR) ? ptr_q :
                   (eff_addr == ffp_pkg::SFR_ACC) ? acc_q :
                   (eff_addr == ffp_pkg::SFR_PCL) ? fa_q[7:0] : 8'h00;
  assign opnd_d = is_sfr ? sfr_val : dmem_rdata_i;

  // eight-bit arithmetic unit, accumulator is the first operand of add, sub, and, or and xor
  logic [ffp_pkg::DW-1:0] b;
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [8:0] alu9;
  logic [ffp_pkg::DW-1:0] wr_val;

  assign b = (cls == ffp_pkg::CL_ALUI) ? fld : opnd_q;
  assign add9 = {1'b0, acc_q} + {1'b0, b};
  assign sub9 = {1'b0, acc_q} - {1'b0, b};
  assign alu9 = (op == ffp_pkg::OP_ADD) ? add9 :
                (op == ffp_pkg::OP_SUB) ? {~sub9[8], sub9[7:0]} :
                (op == ffp_pkg::OP_AND) ? {c_q, acc_q & b} :
                (op == ffp_pkg::OP_OR) ? {c_q, acc_q | b} :
                (op == ffp_pkg::OP_XOR) ? {c_q, acc_q ^ b} :
                (op == ffp_pkg::OP_MOV) ? {c_q, b} :
                (op == ffp_pkg::OP_INC) ? {c_q, 8'(b + 8'h01)} :
                {b[7], b[6:0], c_q};
  // stores carry the accumulator, everything else the unit's result
  assign wr_val = (cls == ffp_pkg::CL_STORE) ? acc_q : alu9[7:0];

  // execution effects, all taken at the end of the fourth phase
  logic exec;
  logic is_alu;
  logic do_write;
  logic acc_wr;
  logic pcl_wr;
  logic skip_taken;
  logic flush;
  logic halt_req;
  logic [ffp_pkg::PC_W-1:0] next_fa;

  assign exec = run && (ph == ffp_pkg::PH_T4);
  assign is_alu = (cls == ffp_pkg::CL_ALUM) || (cls == ffp_pkg::CL_ALUI);
  assign do_write = exec && (((cls == ffp_pkg::CL_ALUM) && dest_mem) ||
                             (cls == ffp_pkg::CL_STORE));
  assign acc_wr = (exec && is_alu && !dest_mem) ||
                  (do_write && eff_addr == ffp_pkg::SFR_ACC);
  assign pcl_wr = do_write && (eff_addr == ffp_pkg::SFR_PCL);
  assign skip_taken = exec && (cls == ffp_pkg::CL_SKIP) &&
                      ((opnd_q == 8'h00) ^ ir_q[ffp_pkg::SKIP_INV_BIT]);
  assign halt_req = exec && (cls == ffp_pkg::CL_SYS) && ir_q[ffp_pkg::HALT_BIT];
  // any change of flow throws away the word fetched alongside it
  assign flush = skip_taken || pcl_wr || (exec && (cls == ffp_pkg::CL_JMP ||
                 cls == ffp_pkg::CL_CALL || cls == ffp_pkg::CL_RET));
  assign next_fa = (exec && (cls == ffp_pkg::CL_JMP || cls == ffp_pkg::CL_CALL)) ?
                   ir_q[ffp_pkg::PC_W-1:0] :
                   (exec && cls == ffp_pkg::CL_RET) ? stk_q[SP_W'(sp_q - 1'b1)] :
                   pcl_wr ? {pc_q[ffp_pkg::PC_W-1:8], wr_val} : pc_q;

  // fetch side: pc steps as the first phase begins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fa_q <= ffp_pkg::PC_RST;
      pc_q <= 11'(ffp_pkg::PC_RST + 11'h001);
      fetch_q <= ffp_pkg::NOP_WORD;
      ir_q <= ffp_pkg::NOP_WORD;
    end else begin
      if (run && ph == ffp_pkg::PH_T2) begin
        fetch_q <= pmem_data_i;
      end
      if (exec) begin
        fa_q <= next_fa;
        pc_q <= 11'(next_fa + 11'h001);
        ir_q <= flush ? ffp_pkg::NOP_WORD : fetch_q;
      end
    end
  end

  // datapath registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= ffp_pkg::ACC_RST;
      ptr_q <= 8'h00;
      opnd_q <= 8'h00;
      c_q <= 1'b0;
      sp_q <= '0;
    end else begin
      if (run && ph == ffp_pkg::PH_T3) begin
        opnd_q <= opnd_d;
      end
      if (acc_wr) begin
        acc_q <= wr_val;
      end
      if (do_write && eff_addr == ffp_pkg::SFR_PTR) begin
        ptr_q <= wr_val;
      end
      if (exec && is_alu) begin
        c_q <= alu9[8];
      end
      if (exec && cls == ffp_pkg::CL_CALL) begin
        sp_q <= SP_W'(sp_q + 1'b1);
      end else if (exec && cls == ffp_pkg::CL_RET) begin
        sp_q <= SP_W'(sp_q - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (exec && cls == ffp_pkg::CL_CALL) begin
      stk_q[sp_q] <= fa_q;
    end
  end

  // data memory port: address during phases two to four, write during next T1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_addr_q <= 8'h00;
      dmem_we_q <= 1'b0;
      dmem_wdata_q <= 8'h00;
    end else begin
      if (run && ph == ffp_pkg::PH_T1) begin
        dmem_addr_q <= eff_addr;
      end
      dmem_we_q <= do_write && !is_sfr;
      if (do_write) begin
        dmem_wdata_q <= wr_val;
      end
    end
  end

  // halt and start-up timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ffp_pkg::ST_RUN;
      cnt_q <= '0;
    end else begin
      case (st_q)
        ffp_pkg::ST_RUN: begin
          if (halt_req) begin
            st_q <= ffp_pkg::ST_HALT;
          end
        end
        ffp_pkg::ST_HALT: begin
          if (wake_s) begin
            st_q <= ffp_pkg::ST_START;
            cnt_q <= rc_s ? CNT_W'(SST_RC_CYC - 1) : CNT_W'(SST_CRYSTAL_OSCILLATOR_CYC - 1);
          end
        end
        ffp_pkg::ST_START: begin
          if (cnt_q == '0) begin
            st_q <= ffp_pkg::ST_RUN;
          end else begin
            cnt_q <= CNT_W'(cnt_q - 1'b1);
          end
        end
        default: begin
          st_q <= ffp_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign pmem_addr_o = fa_q;
  assign pmem_rd_o = run && (ph == ffp_pkg::PH_T1);
  assign dmem_addr_o = dmem_addr_q;
  assign dmem_we_o = dmem_we_q;
  assign dmem_wdata_o = dmem_wdata_q;
  assign halted_o = !run;
  assign acc_o = acc_q;
  assign pc_o = pc_q;

  a_fetch_step: assert property (@(posedge clk_i) disable iff (rst_i)
    pmem_rd_o |-> pc_q == 11'(fa_q + 11'h001))
    else $error("pc not one ahead of the fetch address in T1");

  a_exec_only_t4: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(acc_q) |-> $past(ph) == ffp_pkg::PH_T4)
    else $error("accumulator changed outside the fourth phase");

  a_overlap_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && !flush |=> ir_q == $past(fetch_q))
    else $error("fetched word not passed to execution");

  a_branch_two: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cls == ffp_pkg::CL_JMP |=> ir_q == ffp_pkg::NOP_WORD &&
    fa_q == $past(ir_q[10:0]) ##4 ir_q == $past(pmem_data_i, 3))
    else $error("jump did not take two cycles to its target");

  a_alu_add: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cls == ffp_pkg::CL_ALUI && op == ffp_pkg::OP_ADD && !dest_mem
    |=> acc_q == 8'($past(acc_q) + $past(ir_q[7:0])))
    else $error("eight-bit add result wrong");

  a_store_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cls == ffp_pkg::CL_STORE && !is_sfr |=> dmem_we_o &&
    dmem_wdata_o == $past(acc_q))
    else $error("store did not write the accumulator");

  a_indirect_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    run && ph == ffp_pkg::PH_T2 && fld == ffp_pkg::SFR_IND |-> dmem_addr_o == ptr_q)
    else $error("indirect access not through the pointer");

  a_wake_count: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ffp_pkg::ST_START |=> (st_q == ffp_pkg::ST_START &&
    cnt_q == CNT_W'($past(cnt_q) - 1'b1)) || ($past(cnt_q) == '0 && run))
    else $error("start-up count did not step by one");

  a_skip_dummy: assert property (@(posedge clk_i) disable iff (rst_i)
    skip_taken |=> ir_q == ffp_pkg::NOP_WORD && fa_q == $past(pc_q))
    else $error("taken skip did not insert a dummy cycle");

  a_pcl_page: assert property (@(posedge clk_i) disable iff (rst_i)
    pcl_wr |=> ir_q == ffp_pkg::NOP_WORD &&
    fa_q == {$past(pc_q[10:8]), $past(wr_val)})
    else $error("pc low byte write left the page or skipped the dummy");

endmodule // ffp_core

//--- tb/ffp_mem_model.sv
// program and data memory model facing the sequencer
`timescale 1ns/1ps
module ffp_mem_model (
  // clock
  input wire logic clk_i,
  // program memory
  input wire logic [ffp_pkg::PC_W-1:0] pmem_addr_i,
  input wire logic pmem_rd_i,
  output logic [ffp_pkg::IW-1:0] pmem_data_o,
  // data memory
  input wire logic [ffp_pkg::AW-1:0] dmem_addr_i,
  input wire logic dmem_we_i,
  input wire logic [ffp_pkg::DW-1:0] dmem_wdata_i,
  output logic [ffp_pkg::DW-1:0] dmem_rdata_o
);
  logic [ffp_pkg::IW-1:0] prog [0:2047];
  logic [ffp_pkg::DW-1:0] dmem [0:255];
  // the word stands one cycle after a fetch, then toggles every cycle, so stale data reads back true every second cycle
  always @(posedge clk_i) begin
    if (pmem_rd_i)
      pmem_data_o <= prog[pmem_addr_i];
    else
      pmem_data_o <= ~pmem_data_o;
    if (dmem_we_i)
      dmem[dmem_addr_i] <= dmem_wdata_i;
    dmem_rdata_o <= dmem[dmem_addr_i];
  end
endmodule // ffp_mem_model

//--- tb/tb_top.sv
// self-checking bench for the four-phase sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int XN = 32;
  localparam int RN = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wake_i = 1'b0;
  logic osc_rc_i = 1'b0;
  logic [ffp_pkg::PC_W-1:0] pmem_addr_o;
  logic pmem_rd_o;
  logic [ffp_pkg::IW-1:0] pmem_data_i;
  logic [ffp_pkg::AW-1:0] dmem_addr_o;
  logic dmem_we_o;
  logic [ffp_pkg::DW-1:0] dmem_wdata_o;
  logic [ffp_pkg::DW-1:0] dmem_rdata_i;
  logic [3:0] phase_clocks_o;
  logic halted_o;
  logic [ffp_pkg::DW-1:0] acc_o;
  logic [ffp_pkg::PC_W-1:0] pc_o;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int log_n = 0;
  logic [10:0] flog [0:31];
  logic ctl_watch = 1'b0;

  ffp_core #(.SST_CRYSTAL_OSCILLATOR_CYC(XN), .SST_RC_CYC(RN), .STACK_DEPTH(ffp_pkg::STACK_DEPTH)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
    .pmem_data_i(pmem_data_i), .dmem_addr_o(dmem_addr_o), .dmem_we_o(dmem_we_o),
    .dmem_wdata_o(dmem_wdata_o), .dmem_rdata_i(dmem_rdata_i), .wake_i(wake_i),
    .osc_rc_i(osc_rc_i), .phase_clocks_o(phase_clocks_o), .halted_o(halted_o),
    .acc_o(acc_o), .pc_o(pc_o)
  );

  ffp_mem_model u_mem (
    .clk_i(clk_i), .pmem_addr_i(pmem_addr_o), .pmem_rd_i(pmem_rd_o),
    .pmem_data_o(pmem_data_i), .dmem_addr_i(dmem_addr_o), .dmem_we_i(dmem_we_o),
    .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i)
  );

  always #12.5 clk_i = ~clk_i;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // fetch log, control-register write watch and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (!rst_i && pmem_rd_o === 1'b1 && log_n < 32) begin
      flog[log_n] <= pmem_addr_o;
      log_n <= log_n + 1;
    end
    if (ctl_watch && dmem_we_o === 1'b1)
      check(16'(dmem_addr_o >= 8'h04), 16'h1);
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end

  function automatic logic [15:0] w(input logic [2:0] c, input logic [2:0] o, input logic [7:0] v);
    return {c, 2'b00, o, v};
  endfunction
  function automatic logic [15:0] mv(input logic [7:0] v);
    return w(ffp_pkg::CL_ALUI, ffp_pkg::OP_MOV, v);
  endfunction
  function automatic logic [15:0] st(input logic [7:0] a);
    return w(ffp_pkg::CL_STORE, 3'h0, a);
  endfunction
  function automatic logic [15:0] hl();
    return w(ffp_pkg::CL_SYS, 3'h0, 8'h01);
  endfunction

  task automatic put(input int a, input logic [15:0] q [$]);
    foreach (q[i]) u_mem.prog[a + i] = q[i];
  endtask
  task automatic clear_mem();
    for (int i = 0; i < 2048; i++) u_mem.prog[i] = ffp_pkg::NOP_WORD;
    for (int i = 0; i < 256; i++) u_mem.dmem[i] = 8'h00;
    log_n = 0;
  endtask
  task automatic do_reset(input int n);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (n) @(negedge clk_i);
    rst_i = 1'b0;
  endtask
  task automatic wait_halt();
    int k = 0;
    while (halted_o !== 1'b1 && k < 400) begin
      @(negedge clk_i);
      k++;
    end
    check(16'(halted_o), 16'h1);
  endtask
  task automatic chkm(input logic [7:0] a, input logic [7:0] e);
    check(16'(u_mem.dmem[a]), 16'(e));
  endtask

  task automatic t_phases();
    clear_mem();
    do_reset(2);
    for (int i = 0; i < 16; i++) begin
      check(16'(phase_clocks_o), 16'(4'h1 << (i % 4)));
      check(16'(pmem_rd_o), 16'(i % 4 == 0));
      check(16'(pmem_addr_o), 16'(i / 4));
      if (i % 4 == 0) check(16'(pc_o), 16'(i / 4 + 1));
      @(negedge clk_i);
    end
    repeat (2) @(negedge clk_i);
    do_reset(1);
    check(16'(phase_clocks_o), 16'h1);
  endtask

  task automatic t_alu();
    logic [2:0] ops [8] = '{ffp_pkg::OP_ADD, ffp_pkg::OP_SUB, ffp_pkg::OP_AND, ffp_pkg::OP_OR,
                           ffp_pkg::OP_XOR, ffp_pkg::OP_MOV, ffp_pkg::OP_INC, ffp_pkg::OP_RLC};
    logic [7:0] ex [8] = '{8'h90, 8'h72, 8'h01, 8'h8F, 8'h8E, 8'h0F, 8'h10, 8'h1F};
    clear_mem();
    for (int k = 0; k < 8; k++)
      put(3 * k, {mv(8'h81), w(ffp_pkg::CL_ALUI, ops[k], 8'h0F), st(8'h20 + 8'(k))});
    // inverted skip taken, plain skip not taken, then an add whose result goes to memory
    put(24, {w(ffp_pkg::CL_ALUM, ffp_pkg::OP_ADD, 8'h20), st(8'h28),
             w(ffp_pkg::CL_SKIP, 3'h1, 8'h02), mv(8'h00),
             w(ffp_pkg::CL_SKIP, 3'h0, 8'h02), mv(8'h5A),
             w(ffp_pkg::CL_ALUM, ffp_pkg::OP_ADD, 8'h28) | (16'h0001 << ffp_pkg::DEST_BIT),
             st(8'h29), hl()});
    do_reset(2);
    wait_halt();
    for (int k = 0; k < 8; k++) chkm(8'h20 + 8'(k), ex[k]);
    chkm(8'h28, 8'h09);
    chkm(8'h29, 8'h5A);
  endtask

  task automatic t_ctrl();
    clear_mem();
    put(0, {mv(8'h30), st(8'h01), mv(8'h77), st(8'h00),
            w(ffp_pkg::CL_ALUM, ffp_pkg::OP_ADD, 8'h02), st(8'h32), mv(8'h00),
            w(ffp_pkg::CL_ALUM, ffp_pkg::OP_MOV, 8'h00), st(8'h31), hl()});
    ctl_watch = 1'b1;
    do_reset(2);
    wait_halt();
    ctl_watch = 1'b0;
    chkm(8'h30, 8'h77);
    chkm(8'h32, 8'hEE);
    chkm(8'h31, 8'h77);
    chkm(8'h00, 8'h00);
    chkm(8'h01, 8'h00);
  endtask

  task automatic t_flow();
    logic [10:0] ef [18] = '{0, 1, 2, 3, 4, 5, 16, 17, 18, 32, 33, 34, 18, 19, 20, 21, 72, 73};
    clear_mem();
    put(0, {mv(8'h00), w(ffp_pkg::CL_SKIP, 3'h0, 8'h02), mv(8'h55), st(8'h43),
            w(ffp_pkg::CL_JMP, 3'h0, 8'h10), mv(8'h66)});
    put(16, {st(8'h44), w(ffp_pkg::CL_CALL, 3'h0, 8'h20), st(8'h40), mv(8'h48), st(8'h03),
             mv(8'h77)});
    put(32, {mv(8'h33), w(ffp_pkg::CL_RET, 3'h0, 8'h00), mv(8'h99)});
    put(72, {st(8'h41), hl()});
    do_reset(2);
    wait_halt();
    for (int i = 0; i < 18; i++) check(16'(flog[i]), 16'(ef[i]));
    chkm(8'h43, 8'h00);
    chkm(8'h44, 8'h00);
    chkm(8'h40, 8'h33);
    chkm(8'h41, 8'h48);
    check(16'(acc_o), 16'h48);
  endtask

  task automatic t_wake();
    int cnt;
    int n;
    clear_mem();
    put(0, {mv(8'h11), hl(), st(8'h42), hl()});
    do_reset(2);
    for (int k = 0; k < 2; k++) begin
      wait_halt();
      @(negedge clk_i);
      check(16'(phase_clocks_o), 16'h0);
      check(16'(pmem_rd_o), 16'h0);
      osc_rc_i = (k == 0);
      n = (k == 0) ? RN : XN;
      @(negedge clk_i);
      wake_i = 1'b1;
      cnt = 0;
      while (halted_o !== 1'b0 && cnt < 200) begin
        @(negedge clk_i);
        cnt++;
      end
      wake_i = 1'b0;
      // two synchroniser stages and the load edge come before the count itself
      check(16'(cnt), 16'(n + 3));
      check(16'(phase_clocks_o), 16'h1);
    end
    chkm(8'h42, 8'h11);
  endtask

  initial begin
    do_reset(12);
    t_phases();
    t_alu();
    t_ctrl();
    t_flow();
    t_wake();
    end_of_test();
  end
endmodule // tb_top
